// ---- pkg/etd_cfg.svh ----
`ifndef ETD_CFG_SVH
`define ETD_CFG_SVH
// Register byte addresses on the APB slave
`define ETD_ADDR_DIV_HIGH 8'h00
`define ETD_ADDR_DIV_LOW 8'h04
`define ETD_ADDR_CONFIG 8'h08
`define ETD_ADDR_NV_HIGH 8'h0C
`define ETD_ADDR_NV_LOW 8'h10
`define ETD_ADDR_STATUS 8'h14
// Field positions
`define ETD_LOCK_DISABLE_BIT 7
`define ETD_CLOCK_SELECT_BIT 0
`define ETD_LATCH_ENABLE_BIT 1
`define ETD_WRITE_ENABLE_BIT 2
// Divisor geometry and reset values
`define ETD_DIV_WIDTH 11
`define ETD_HIGH_FIELD_WIDTH 3
`define ETD_NV_HIGH_ERASED 8'h87
`define ETD_NV_LOW_ERASED 8'hFF
// Timing
`define ETD_TICK_PERIOD_NS 35000
`define ETD_MCLK_PERIOD_NS 40
`endif

// ---- pkg/etd_pkg.sv ----
package etd_pkg;
    // Divider reference source
    typedef enum logic {
        etd_ref_oscillator,
        etd_ref_bus
    } etd_ref_type;
    // Reset loader progress
    typedef enum logic [1:0] {
        etd_load_idle,
        etd_load_copy,
        etd_load_done
    } etd_load_type;
endpackage : etd_pkg

// ---- pkg/etd_div_if.sv ----
`timescale 1ns/1ns
// Divisor and reference enables travelling from the registers to the counter
interface etd_div_if;
    logic [10:0] divisor;
    logic ref_pulse;
    logic tick;
    logic running;
    modport regs (output divisor, output ref_pulse, input tick, input running);
    modport counter (input divisor, input ref_pulse, output tick, output running);
endinterface : etd_div_if

// ---- design/etd_ref_select.sv ----
`timescale 1ns/1ns
`include "etd_cfg.svh"
// Picks the reference source and turns its rising edges into one-mclk pulses.
// Both references arrive synchronous to mclk, as slow enable-style levels.
module etd_ref_select
    import etd_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic oscillator_output_clock,
    input wire logic bus_clock,
    input wire etd_ref_type divisor_clock_select,
    output logic ref_pulse
);
    logic selected; // Chosen reference level
    logic last; // Previous level, for edge detection

    // Source mux
    always_comb begin
        selected = (divisor_clock_select == etd_ref_bus) ? bus_clock : oscillator_output_clock;
    end

    // Remember the level
    always_ff @(posedge mclk) begin
        if (rst) begin
            last <= 1'b0;
        end else begin
            last <= selected;
        end
    end

    // A source switch may produce one stray edge; software reloads the divisor anyway
    assign ref_pulse = selected & ~last;
endmodule : etd_ref_select

// ---- design/etd_counter.sv ----
`timescale 1ns/1ns
`include "etd_cfg.svh"
// Counts reference edges up to the divisor and emits a one-cycle tick.
module etd_counter
    import etd_pkg::*;
#(
    parameter int DIV_WIDTH = `ETD_DIV_WIDTH
) (
    input wire logic mclk,
    input wire logic rst,
    etd_div_if.counter div
);
    logic [DIV_WIDTH-1:0] count; // Reference edges since last tick
    logic tick_q; // Registered tick

    // Count, wrap at terminal count
    always_ff @(posedge mclk) begin
        if (rst) begin
            count <= '0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= 1'b0;
            if (div.ref_pulse && div.divisor != '0) begin
                if (count >= div.divisor - 1'b1) begin
                    count <= '0;
                    tick_q <= 1'b1;
                end else begin
                    count <= count + 1'b1;
                end
            end
        end
    end

    assign div.tick = tick_q;
    // A zero divisor stops the timebase rather than ticking every edge
    assign div.running = (div.divisor != '0);

    // Tick never follows a tick without a reference edge between
    tick_gap_a: assert property (@(posedge mclk) disable iff (rst)
        div.tick |-> !$past(div.tick)) else $error("back to back ticks");
endmodule : etd_counter

// ---- design/etd_timebase.sv ----
`timescale 1ns/1ns
`include "etd_cfg.svh"
module etd_timebase
    import etd_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic oscillator_output_clock,
    input wire logic bus_clock,
    input wire logic eeprom_latch_enable,
    input wire logic nv_program_req,
    input wire logic nv_erase_req,
    input wire logic nv_select_high,
    input wire logic [7:0] nv_program_data,
    output logic nv_blocked,
    output logic timebase_tick
);
    localparam int DIV_WIDTH = `ETD_DIV_WIDTH;
    // Divider cycles per tick at the mclk rate, for information only
    localparam int TICK_MCLK = `ETD_TICK_PERIOD_NS / `ETD_MCLK_PERIOD_NS;

    logic [2:0] timebase_divisor_high; // Upper divisor bits
    logic divisor_lock_disable; // One: lock off
    logic [7:0] timebase_divisor_low; // Lower divisor bits
    // The cells power up erased and rst never touches them, so a fresh part is
    // unlocked after the first reload; rst itself locks it, so software can program both bytes only after that reload
    logic [7:0] divisor_high_nonvolatile = `ETD_NV_HIGH_ERASED; // Nonvolatile high byte
    logic [7:0] divisor_low_nonvolatile = `ETD_NV_LOW_ERASED; // Nonvolatile low byte
    etd_ref_type divisor_clock_select; // Reference choice
    logic write_enable; // Gate for the proposed addresses
    etd_load_type load_state; // Reset loader
    logic [31:0] next_prdata; // Read mux
    logic wr_strobe; // APB access-phase write
    logic div_writable; // Divisor may take a write
    logic locked; // Security active

    etd_div_if div_bus();

    // APB answers in the access phase with no wait
    assign pready = 1'b1;
    assign wr_strobe = psel & penable & pwrite;
    assign locked = ~divisor_lock_disable;
    assign div_writable = write_enable & ~eeprom_latch_enable & ~locked;
    assign nv_blocked = locked;

    // Unmapped address reports an error
    always_comb begin
        pslverr = 1'b0;
        if (psel && penable) begin
            unique case (paddr)
                `ETD_ADDR_DIV_HIGH, `ETD_ADDR_DIV_LOW, `ETD_ADDR_CONFIG,
                `ETD_ADDR_NV_HIGH, `ETD_ADDR_NV_LOW, `ETD_ADDR_STATUS: pslverr = 1'b0;
                default: pslverr = 1'b1;
            endcase
        end
    end

    // Reset loader: one cycle after reset release the nonvolatile copy lands
    // The idle state is never entered; the loader rests in done until the next rst
    always_ff @(posedge mclk) begin
        if (rst) begin
            load_state <= etd_load_copy;
        end else begin
            unique case (load_state)
                etd_load_idle: load_state <= etd_load_idle;
                etd_load_copy: load_state <= etd_load_done;
                etd_load_done: load_state <= etd_load_done;
            endcase
        end
    end

    // Volatile divisor registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            timebase_divisor_high <= 3'h0;
            timebase_divisor_low <= 8'h00;
            divisor_lock_disable <= 1'b0;
        end else if (load_state == etd_load_copy) begin
            // Only path from the nonvolatile bytes into the divisor
            timebase_divisor_high <= divisor_high_nonvolatile[2:0];
            divisor_lock_disable <= divisor_high_nonvolatile[`ETD_LOCK_DISABLE_BIT];
            timebase_divisor_low <= divisor_low_nonvolatile;
        end else if (wr_strobe && div_writable) begin
            if (paddr == `ETD_ADDR_DIV_HIGH) begin
                timebase_divisor_high <= pwdata[2:0];
                divisor_lock_disable <= pwdata[`ETD_LOCK_DISABLE_BIT];
            end
            if (paddr == `ETD_ADDR_DIV_LOW) begin
                timebase_divisor_low <= pwdata[7:0];
            end
        end
    end

    // Nonvolatile bytes survive rst: they only change by program/erase
    // Erase wins when both requests arrive in one cycle
    always_ff @(posedge mclk) begin
        if (!locked && nv_erase_req) begin
            if (nv_select_high) begin
                divisor_high_nonvolatile <= `ETD_NV_HIGH_ERASED;
            end else begin
                divisor_low_nonvolatile <= `ETD_NV_LOW_ERASED;
            end
        end else if (!locked && nv_program_req) begin
            // Programming only clears bits, as in real cells
            if (nv_select_high) begin
                divisor_high_nonvolatile <= divisor_high_nonvolatile & nv_program_data;
            end else begin
                divisor_low_nonvolatile <= divisor_low_nonvolatile & nv_program_data;
            end
        end
    end

    // Configuration register: clock select, write gate
    // A source change needs a fresh divisor from software; nothing reloads it here
    always_ff @(posedge mclk) begin
        if (rst) begin
            divisor_clock_select <= etd_ref_oscillator;
            write_enable <= 1'b0;
        end else if (wr_strobe && paddr == `ETD_ADDR_CONFIG) begin
            divisor_clock_select <= etd_ref_type'(pwdata[`ETD_CLOCK_SELECT_BIT]);
            write_enable <= pwdata[`ETD_WRITE_ENABLE_BIT];
        end
    end

    // Read mux, always available
    always_comb begin
        next_prdata = 32'h0000_0000;
        unique case (paddr)
            `ETD_ADDR_DIV_HIGH: next_prdata = {24'h0, divisor_lock_disable, 4'h0,
                timebase_divisor_high};
            `ETD_ADDR_DIV_LOW: next_prdata = {24'h0, timebase_divisor_low};
            `ETD_ADDR_CONFIG: next_prdata = {29'h0, write_enable, 1'b0,
                divisor_clock_select};
            `ETD_ADDR_NV_HIGH: next_prdata = {24'h0, divisor_high_nonvolatile};
            `ETD_ADDR_NV_LOW: next_prdata = {24'h0, divisor_low_nonvolatile};
            `ETD_ADDR_STATUS: next_prdata = {29'h0, div_bus.running,
                eeprom_latch_enable, locked};
            default: next_prdata = 32'h0000_0000;
        endcase
    end

    // Read data held in a flip-flop, loaded in the setup phase
    always_ff @(posedge mclk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= next_prdata;
        end
    end

    assign div_bus.divisor = {timebase_divisor_high, timebase_divisor_low};

    etd_ref_select u_ref (
        .mclk(mclk),
        .rst(rst),
        .oscillator_output_clock(oscillator_output_clock),
        .bus_clock(bus_clock),
        .divisor_clock_select(divisor_clock_select),
        .ref_pulse(div_bus.ref_pulse)
    );

    etd_counter #(.DIV_WIDTH(DIV_WIDTH)) u_cnt (
        .mclk(mclk),
        .rst(rst),
        .div(div_bus.counter)
    );

    assign timebase_tick = div_bus.tick;

    // Antecedents that could start on the release edge also test the sampled rst,
    // because the disable condition only sees the value after that edge
    // Reset load in two steps: the copy edge, then the bytes as they stood there
    sequence load_step_s;
        !rst && load_state == etd_load_copy;
    endsequence
    sequence high_landed_s;
        timebase_divisor_high == $past(divisor_high_nonvolatile[2:0]);
    endsequence
    sequence lock_landed_s;
        divisor_lock_disable == $past(divisor_high_nonvolatile[`ETD_LOCK_DISABLE_BIT]);
    endsequence
    // Software divisor write as a step: a granted strobe to one of the two halves
    sequence low_write_s;
        load_state == etd_load_done && wr_strobe && div_writable && paddr == `ETD_ADDR_DIV_LOW;
    endsequence
    sequence high_write_s;
        load_state == etd_load_done && wr_strobe && div_writable && paddr == `ETD_ADDR_DIV_HIGH;
    endsequence
    // Locked divisor cannot change except through the loader
    lock_hold_a: assert property (@(posedge mclk) disable iff (rst)
        (locked && load_state == etd_load_done) |=> $stable(div_bus.divisor))
        else $error("divisor changed while locked");
    // The lock bit cannot release itself by a write
    lock_bit_hold_a: assert property (@(posedge mclk) disable iff (rst)
        (locked && load_state == etd_load_done) |=> locked)
        else $error("lock released without reset");
    // Latch set blocks divisor writes
    latch_block_a: assert property (@(posedge mclk) disable iff (rst)
        (eeprom_latch_enable && wr_strobe && load_state == etd_load_done)
        |=> ($stable(div_bus.divisor) && $stable(divisor_lock_disable)))
        else $error("write under latch");
    // Without the write gate the divisor and lock bit do not move
    gate_off_a: assert property (@(posedge mclk) disable iff (rst)
        (!write_enable && load_state == etd_load_done)
        |=> ($stable(div_bus.divisor) && $stable(divisor_lock_disable)))
        else $error("write with gate off");
    // Gate and clock select move only on a configuration write
    config_hold_a: assert property (@(posedge mclk) disable iff (rst)
        (!rst && !(wr_strobe && paddr == `ETD_ADDR_CONFIG))
        |=> ($stable(write_enable) && $stable(divisor_clock_select)))
        else $error("configuration moved without a write");
    // A configuration write lands on the access edge
    config_land_a: assert property (@(posedge mclk) disable iff (rst)
        (!rst && wr_strobe && paddr == `ETD_ADDR_CONFIG)
        |=> (write_enable == $past(pwdata[`ETD_WRITE_ENABLE_BIT])
        && divisor_clock_select == etd_ref_type'($past(pwdata[`ETD_CLOCK_SELECT_BIT]))))
        else $error("configuration write lost");
    // Low nonvolatile byte frozen under lock
    nv_frozen_a: assert property (@(posedge mclk)
        locked |=> $stable(divisor_low_nonvolatile))
        else $error("nonvolatile byte changed while locked");
    // The high nonvolatile byte, which holds the lock bit, is frozen as well
    blocked_out_a: assert property (@(posedge mclk)
        (nv_blocked && (nv_program_req || nv_erase_req)) |=> $stable(divisor_high_nonvolatile))
        else $error("nonvolatile high byte changed while blocked");
    // Unlocked erase of the low byte leaves it in the erased pattern
    nv_erase_a: assert property (@(posedge mclk)
        (!locked && nv_erase_req && !nv_select_high)
        |=> divisor_low_nonvolatile == `ETD_NV_LOW_ERASED)
        else $error("nonvolatile erase result wrong");
    // Unlocked programming of the high byte only clears its bits
    nv_program_a: assert property (@(posedge mclk)
        (!locked && nv_program_req && !nv_erase_req && nv_select_high)
        |=> divisor_high_nonvolatile
        == ($past(divisor_high_nonvolatile) & $past(nv_program_data)))
        else $error("nonvolatile program result wrong");
    // Loader copies the low byte one cycle after release
    load_copy_a: assert property (@(posedge mclk) disable iff (rst)
        load_step_s |=> timebase_divisor_low == $past(divisor_low_nonvolatile))
        else $error("reset copy missed");
    // Loader copies the high divisor bits at the same edge
    load_high_a: assert property (@(posedge mclk) disable iff (rst)
        load_step_s |=> high_landed_s)
        else $error("high divisor bits not reloaded");
    // Lock bit follows the nonvolatile bit after reset
    lock_reload_a: assert property (@(posedge mclk) disable iff (rst)
        (!rst && load_state == etd_load_copy
        && !divisor_high_nonvolatile[`ETD_LOCK_DISABLE_BIT]) |=> locked)
        else $error("lock not reloaded");
    // Lock disable bit is a plain copy of its nonvolatile twin
    load_lock_a: assert property (@(posedge mclk) disable iff (rst)
        load_step_s |=> lock_landed_s)
        else $error("lock disable bit not reloaded");
    // Granted divisor writes land on the access edge
    low_write_a: assert property (@(posedge mclk) disable iff (rst)
        low_write_s |=> timebase_divisor_low == $past(pwdata[7:0]))
        else $error("low divisor write lost");
    high_write_a: assert property (@(posedge mclk) disable iff (rst)
        high_write_s |=> (timebase_divisor_high == $past(pwdata[2:0])
        && divisor_lock_disable == $past(pwdata[`ETD_LOCK_DISABLE_BIT])))
        else $error("high divisor write lost");
    // Read data is captured in the setup cycle and then stands
    read_setup_a: assert property (@(posedge mclk) disable iff (rst)
        (!rst && psel && !penable && !pwrite) |=> prdata == $past(next_prdata))
        else $error("read data not captured");
    read_hold_a: assert property (@(posedge mclk) disable iff (rst)
        (!rst && !(psel && !penable && !pwrite)) |=> $stable(prdata))
        else $error("read data moved outside a setup cycle");
    // Unmapped addresses answer with an error, mapped ones do not
    unmapped_err_a: assert property (@(posedge mclk) disable iff (rst)
        (psel && penable) |-> (pslverr == (paddr > `ETD_ADDR_STATUS || paddr[1:0] != 2'h0)))
        else $error("slave error flag wrong");
    // Ticks only appear with a nonzero divisor
    tick_cause_a: assert property (@(posedge mclk) disable iff (rst)
        timebase_tick |-> $past(div_bus.divisor != 11'h000))
        else $error("tick with zero divisor");
    // Nonvolatile writes never reach the divisor after the load
    nv_isolate_a: assert property (@(posedge mclk) disable iff (rst)
        (load_state == etd_load_done && !wr_strobe) |=> $stable(div_bus.divisor))
        else $error("divisor moved without a write");
endmodule : etd_timebase

// ---- tb/etd_timebase_tb.sv ----
`timescale 1ns/1ns
`include "etd_cfg.svh"
// Bench for the timebase divider: APB master, reference levels, integer model
module etd_timebase_tb;
    logic mclk;
    logic rst;
    logic psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr;
    logic osc, bus;
    logic [1:0] rc;
    logic lat, pgm, ers, nsh;
    logic [7:0] npd;
    logic nv_blocked, timebase_tick;
    // Model state, plain integers
    int div, lk, we, sel, nvh, nvl, d;
    int error_cnt, n_checks;
    int seed = 21531;
    logic [31:0] rd;
    logic err;

    etd_timebase u_etd_timebase (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .oscillator_output_clock(osc), .bus_clock(bus),
        .eeprom_latch_enable(lat), .nv_program_req(pgm), .nv_erase_req(ers),
        .nv_select_high(nsh), .nv_program_data(npd), .nv_blocked(nv_blocked),
        .timebase_tick(timebase_tick));

    // 25 MHz clock
    always #20 mclk = ~mclk;

    // Oscillator level toggles each cycle, bus level at half that rate
    always @(posedge mclk) begin
        rc <= rc + 2'h1;
        osc <= ~osc;
        bus <= rc[1];
    end

    task automatic print_verdict;
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict

    // A wait that ran out counts as a mismatch and ends the run
    task automatic hang;
        error_cnt++;
        $display("ERROR t=%0t wait bound exhausted", $time);
        print_verdict();
    endtask : hang

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    // One APB transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) hang();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb

    // Write and mirror the gated effect in the model
    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd);
        if (a == `ETD_ADDR_CONFIG) begin
            we = wd[2];
            sel = wd[0];
        end
        // Divisor writes only when enabled, unlatched and unlocked
        if (we == 1 && lat == 1'b0 && lk == 1) begin
            if (a == `ETD_ADDR_DIV_HIGH) begin
                div = (wd[2:0] << 8) | (div & 255);
                lk = wd[7];
            end
            if (a == `ETD_ADDR_DIV_LOW) div = (div & 1792) | wd[7:0];
        end
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd & m, e);
    endtask : rdc

    // Compare all visible divisor state with the model
    task automatic regs;
        rdc(`ETD_ADDR_DIV_HIGH, 32'h87, (lk << 7) | (div >> 8));
        chk(err, 1'b0);
        rdc(`ETD_ADDR_DIV_LOW, 32'hFF, div & 255);
        rdc(`ETD_ADDR_NV_HIGH, 32'hFF, nvh);
        rdc(`ETD_ADDR_NV_LOW, 32'hFF, nvl);
        rdc(`ETD_ADDR_STATUS, 32'h7, (div != 0 ? 4 : 0) | (lat << 1) | (1 - lk));
        chk(nv_blocked, lk == 0);
    endtask : regs

    // Nonvolatile program (AND) or erase, ignored while locked
    task automatic nvop(input logic p, input logic hi, input logic [7:0] v);
        pgm <= p;
        ers <= ~p;
        nsh <= hi;
        npd <= v;
        @(posedge mclk);
        pgm <= 1'b0;
        ers <= 1'b0;
        @(posedge mclk);
        @(posedge mclk);
        if (lk == 1 && hi) nvh = p ? (nvh & v) : `ETD_NV_HIGH_ERASED;
        if (lk == 1 && !hi) nvl = p ? (nvl & v) : `ETD_NV_LOW_ERASED;
    endtask : nvop

    // Reset reloads the divisor from the nonvolatile bytes
    task automatic do_rst;
        rst <= 1'b1;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        repeat (2) @(posedge mclk);
        div = ((nvh & 7) << 8) | nvl;
        lk = (nvh >> 7) & 1;
        we = 0;
        sel = 0;
    endtask : do_rst

    // Gap between the second and third tick is clear of any count begun before a change
    task automatic gap(input int e);
        int k, n;
        for (n = 0; n < 3; n++) begin
            k = 0;
            do begin
                @(posedge mclk);
                k++;
            end while (timebase_tick !== 1'b1 && k < 10000);
            if (k >= 10000) hang();
        end
        chk(k, e);
    endtask : gap

    initial begin
        mclk = 1'b0;
        {rst, osc, bus, rc} = 5'h10;
        {psel, penable, pwrite, lat, pgm, ers, nsh} = 7'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        npd = 8'h00;
        {error_cnt, n_checks, nvh, nvl, lk} = '0;
        lk = 1;
        // Give the nonvolatile bytes a known erased state, then reload
        do_rst();
        lk = 1;
        nvop(1'b0, 1'b1, 8'h00);
        nvop(1'b0, 1'b0, 8'h00);
        do_rst();
        regs();
        $display("test reset load done");
        rdc(8'h18, 32'hFFFFFFFF, 32'h0);
        chk(err, 1'b1);
        wr(`ETD_ADDR_DIV_LOW, 32'h12);
        regs();
        $display("test unmapped and gated write done");
        wr(`ETD_ADDR_CONFIG, 32'h4);
        lat <= 1'b1;
        @(posedge mclk);
        wr(`ETD_ADDR_DIV_LOW, 32'h34);
        regs();
        lat <= 1'b0;
        @(posedge mclk);
        // Oscillator level rises every second mclk: 12.5 MHz, inside the advised range
        d = (12500000 * 35 + 500000) / 1000000;
        wr(`ETD_ADDR_DIV_HIGH, 32'h80 | (d >> 8));
        wr(`ETD_ADDR_DIV_LOW, d & 255);
        regs();
        gap((sel + 1) * 2 * div);
        wr(`ETD_ADDR_CONFIG, 32'h5);
        d = 2 + ($unsigned($random(seed)) % 30);
        wr(`ETD_ADDR_DIV_LOW, d);
        gap((sel + 1) * 2 * div);
        $display("test tick period done");
        nvop(1'b1, 1'b0, 8'h0B);
        regs();
        do_rst();
        regs();
        $display("test reload on reset done");
        nvop(1'b1, 1'b1, 8'h05);
        do_rst();
        regs();
        wr(`ETD_ADDR_CONFIG, 32'h4);
        wr(`ETD_ADDR_DIV_HIGH, 32'h87);
        wr(`ETD_ADDR_DIV_LOW, 32'h00);
        nvop(1'b0, 1'b1, 8'h00);
        nvop(1'b0, 1'b0, 8'h00);
        regs();
        do_rst();
        regs();
        $display("test lock done");
        print_verdict();
    end
endmodule : etd_timebase_tb
